// ### design/sprs_defs.vh
`ifndef SPRS_DEFS_VH
`define SPRS_DEFS_VH

// ==========================================================
// command byte fields
`define SPRS_CMD_RW_BIT      0
`define SPRS_CMD_MODE_BIT    4
`define SPRS_CMD_NORMAL_TAG  3'h3
`define SPRS_UNIT_NUMBER     3'h0

// ==========================================================
// global-page interface registers
`define SPRS_ADDR_PAGE       8'hff
`define SPRS_ADDR_DATA       8'hf0
`define SPRS_ADDR_STATUS     8'hfe
`define SPRS_STAT_DONE_BIT   7
`define SPRS_STAT_READ_ACK_FLAG_BIT   5
`define SPRS_PAGE_RESET      8'h00

// ==========================================================
// timing
`define SPRS_CLK_PERIOD_NS   4
`define SPRS_SEL_GAP_NS      200
`define SPRS_SEL_GAP_CYC     ((`SPRS_SEL_GAP_NS + `SPRS_CLK_PERIOD_NS - 1) / `SPRS_CLK_PERIOD_NS)
`define SPRS_FETCH_TIMEOUT   8'h40
`define SPRS_STRAP_AGE       2'h3

`endif

// ### design/sprs_slave.v
`timescale 1ns/1ps
`include "sprs_defs.vh"

module sprs_slave (
    // clock and reset
    input  wire        clk_sys,
    input  wire        rst_n,
    // strap
    input  wire        host_or_rom_strap,
    // serial pins
    input  wire        spi_ss_n,
    input  wire        spi_sck,
    input  wire        spi_mosi,
    output reg         spi_miso,
    output reg         spi_miso_oe_n,
    // internal register space
    output reg  [7:0]  reg_page,
    output reg  [7:0]  reg_addr,
    output reg  [7:0]  reg_wdata,
    output reg         reg_wr,
    output reg         reg_rd,
    input  wire [7:0]  reg_rdata,
    input  wire        reg_rvalid,
    // status
    output reg         host_port_sel,
    output reg         cmd_error
);

// ==========================================================
// input synchronisers
reg [2:0] ss_sync;
reg [2:0] sck_sync;
reg [2:0] mosi_sync;
reg       ss_n;
reg       sck;
reg       mosi;

function settle;
    input [2:0] s;
    input       cur;
    begin
        settle = (s[1] == s[2]) ? s[2] : cur;
    end
endfunction

always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        ss_sync   <= 3'h7;
        sck_sync  <= 3'h7;
        mosi_sync <= 3'h0;
        ss_n      <= 1'b1;
        sck       <= 1'b1;
        mosi      <= 1'b0;
    end else begin
        ss_sync   <= {ss_sync[1:0], spi_ss_n};
        sck_sync  <= {sck_sync[1:0], spi_sck};
        mosi_sync <= {mosi_sync[1:0], spi_mosi};
        ss_n      <= settle(ss_sync, ss_n);
        sck       <= settle(sck_sync, sck);
        mosi      <= settle(mosi_sync, mosi);
    end
end

// ==========================================================
// strap capture after reset release
reg       strap_done;
reg [2:0] strap_sync;
reg [1:0] strap_age;

always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        strap_sync    <= 3'h7;
        strap_age     <= 2'h0;
        strap_done    <= 1'b0;
        host_port_sel <= 1'b1;
    end else begin
        strap_sync <= {strap_sync[1:0], host_or_rom_strap};
        if (!strap_done) begin
            if (strap_age != `SPRS_STRAP_AGE)
                strap_age <= strap_age + 2'h1;
            else if (strap_sync[1] == strap_sync[2]) begin
                strap_done    <= 1'b1;
                host_port_sel <= strap_sync[2];
            end
        end
    end
end

// ==========================================================
// edge detect
reg  sck_q;
wire active   = host_port_sel && strap_done && !ss_n;
wire sck_rise = active && sck && !sck_q;
wire sck_fall = active && !sck && sck_q;

always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
        sck_q <= 1'b1;
    else
        sck_q <= sck;
end

// ==========================================================
// byte framing
localparam ST_CMD  = 2'h0;
localparam ST_ADDR = 2'h1;
localparam ST_DATA = 2'h2;
localparam ST_SKIP = 2'h3;

reg [1:0] state;
reg [2:0] bit_cnt;
reg [7:0] shift_in;
reg [7:0] shift_out;
reg [7:0] cmd;
reg [7:0] cur_addr;
reg [7:0] data_win;
reg       xfer_done;
reg       read_ack_flag;
reg       fetch_busy;
reg [7:0] fetch_tmr;

wire [7:0] rx_byte  = {shift_in[6:0], mosi};
wire       byte_end = sck_rise && (bit_cnt == 3'h7);

// ==========================================================
// command and address decode
function cmd_ok;
    input [7:0] c;
    begin
        cmd_ok = (c[3:1] == `SPRS_UNIT_NUMBER) &&
                 (c[`SPRS_CMD_MODE_BIT] ||
                  (c[7:5] == `SPRS_CMD_NORMAL_TAG)) &&
                 !(c[`SPRS_CMD_MODE_BIT] && c[`SPRS_CMD_RW_BIT]);
    end
endfunction

function [7:0] read_value;
    input [7:0] a;
    begin
        case (a)
            `SPRS_ADDR_PAGE:   read_value = reg_page;
            `SPRS_ADDR_DATA:   read_value = data_win;
            `SPRS_ADDR_STATUS: read_value = {xfer_done, 1'b0, read_ack_flag, 5'h00};
            default:           read_value = 8'h00;
        endcase
    end
endfunction

function [7:0] start_addr;
    input       fast;
    input [2:0] off;
    input [7:0] a;
    begin
        start_addr = fast ? a + {5'h00, off} : a;
    end
endfunction

function is_iface;
    input [7:0] a;
    begin
        is_iface = (a == `SPRS_ADDR_PAGE) || (a == `SPRS_ADDR_DATA) ||
                   (a == `SPRS_ADDR_STATUS);
    end
endfunction

// ==========================================================
// command fields
wire       is_write   = cmd[`SPRS_CMD_RW_BIT];
wire       is_fast    = cmd[`SPRS_CMD_MODE_BIT];
wire [7:0] first_addr = start_addr(is_fast, cmd[7:5], rx_byte);

// ==========================================================
// transaction state and data window
always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        state      <= ST_CMD;
        bit_cnt    <= 3'h0;
        shift_in   <= 8'h00;
        shift_out  <= 8'h00;
        cmd        <= 8'h00;
        cur_addr   <= 8'h00;
        data_win   <= 8'h00;
        reg_page   <= `SPRS_PAGE_RESET;
        reg_addr   <= 8'h00;
        reg_wdata  <= 8'h00;
        reg_wr     <= 1'b0;
        reg_rd     <= 1'b0;
        xfer_done  <= 1'b0;
        read_ack_flag       <= 1'b0;
        fetch_busy <= 1'b0;
        fetch_tmr  <= 8'h00;
        cmd_error  <= 1'b0;
    end else begin
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        // internal fetch into the data window
        if (fetch_busy) begin
            if (reg_rvalid) begin
                data_win   <= reg_rdata;
                read_ack_flag       <= 1'b1;
                xfer_done  <= 1'b1;
                fetch_busy <= 1'b0;
            end else if (fetch_tmr == `SPRS_FETCH_TIMEOUT) begin
                fetch_busy <= 1'b0;
                xfer_done  <= 1'b1;
            end else begin
                fetch_tmr <= fetch_tmr + 8'h01;
            end
        end
        if (!active) begin
            state   <= ST_CMD;
            bit_cnt <= 3'h0;
        end else begin
            if (sck_rise) begin
                shift_in <= rx_byte;
                bit_cnt  <= bit_cnt + 3'h1;
            end
            if (byte_end) begin
                case (state)
                    ST_CMD: begin
                        cmd       <= rx_byte;
                        cmd_error <= !cmd_ok(rx_byte);
                        state     <= cmd_ok(rx_byte) ? ST_ADDR : ST_SKIP;
                    end
                    ST_ADDR: begin
                        state     <= ST_DATA;
                        cur_addr  <= first_addr;
                        shift_out <= read_value(first_addr);
                        if (!is_write && !is_iface(first_addr)) begin
                            reg_addr   <= first_addr;
                            reg_rd     <= 1'b1;
                            fetch_busy <= 1'b1;
                            fetch_tmr  <= 8'h00;
                            read_ack_flag       <= 1'b0;
                            xfer_done  <= 1'b0;
                        end
                    end
                    ST_DATA: begin
                        cur_addr  <= cur_addr + 8'h01;
                        shift_out <= read_value(cur_addr + 8'h01);
                        if (is_write) begin
                            if (cur_addr == `SPRS_ADDR_PAGE)
                                reg_page <= rx_byte;
                            else begin
                                reg_addr  <= cur_addr;
                                reg_wdata <= rx_byte;
                                reg_wr    <= 1'b1;
                                xfer_done <= 1'b1;
                            end
                        end else if (cur_addr == `SPRS_ADDR_DATA &&
                                     !(fetch_busy && reg_rvalid)) begin
                            read_ack_flag <= 1'b0;
                        end
                    end
                    default: state <= ST_SKIP;
                endcase
            end else if (sck_fall && bit_cnt != 3'h0) begin
                shift_out <= {shift_out[6:0], 1'b0};
            end
        end
    end
end

// ==========================================================
// miso drive
always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        spi_miso      <= 1'b0;
        spi_miso_oe_n <= 1'b1;
    end else begin
        spi_miso_oe_n <= !(active && state == ST_DATA && !is_write);
        if (sck_fall && state == ST_DATA)
            spi_miso <= (bit_cnt == 3'h0) ? shift_out[7] : shift_out[6];
        else if (!active)
            spi_miso <= 1'b0;
    end
end

endmodule

// ### tb/sprs_regs_model.sv
`timescale 1ns/1ps
module sprs_regs_model (
    input  wire       clk_sys,
    input  wire       reg_rd,
    input  wire [7:0] reg_page,
    input  wire [7:0] reg_addr,
    output reg  [7:0] reg_rdata,
    output reg        reg_rvalid
);
    reg [2:0] dly;
    initial begin
        dly = 3'h0;
        reg_rvalid = 1'b0;
        reg_rdata = 8'h00;
    end
    // answer four cycles after a fetch; data toggles when not valid
    always @(posedge clk_sys) begin
        dly <= {dly[1:0], reg_rd};
        reg_rvalid <= dly[2];
        reg_rdata <= dly[2] ? (reg_page ^ reg_addr ^ 8'h5a) : ~reg_rdata;
    end
endmodule

// ### tb/sprs_slave_checker.sv
`timescale 1ns/1ps
module sprs_slave_checker (
    input wire       clk_sys,
    input wire       rst_n,
    input wire       spi_ss_n,
    input wire       spi_miso_oe_n,
    input wire [7:0] reg_page,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire       host_port_sel,
    input wire       cmd_error
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // ==========
    // checks
    property p_oe_idle; spi_ss_n [*8] |-> spi_miso_oe_n; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("miso driven while idle");
    property p_quiet; spi_ss_n [*8] |-> !reg_wr && !reg_rd; endproperty
    a_quiet: assert property (p_quiet) else $error("access while idle");
    property p_page_hold; spi_ss_n [*8] |=> $stable(reg_page); endproperty
    a_page_hold: assert property (p_page_hold) else $error("page moved while idle");
    property p_wr_pulse; reg_wr |=> !reg_wr; endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
    property p_rd_pulse; reg_rd |=> !reg_rd; endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("fetch strobe too long");
    property p_strap; !host_port_sel |-> !reg_wr && !reg_rd; endproperty
    a_strap: assert property (p_strap) else $error("access with rom strap");
    property p_strap_hold; !host_port_sel |=> !host_port_sel; endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap changed");
    property p_err_block; cmd_error |-> !reg_wr; endproperty
    a_err_block: assert property (p_err_block) else $error("write after bad command");
    c_wr: cover property (reg_wr);
    c_rd: cover property (reg_rd);
    c_err: cover property ($rose(cmd_error));
endmodule
bind sprs_slave sprs_slave_checker u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
    .spi_ss_n(spi_ss_n), .spi_miso_oe_n(spi_miso_oe_n), .reg_page(reg_page),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .host_port_sel(host_port_sel), .cmd_error(cmd_error));

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
    reg        clk_sys, rst_n, strap, ss_n, sck, mosi;
    wire       miso, oe_n, wr, rd, rv, hps, err;
    wire [7:0] page, addr, wd, rdat;
    reg  [7:0] tx_b [0:3];
    reg  [7:0] rx_b [0:3];
    reg  [7:0] pg, ad, d0, d1, wa_prev, wa_last, ra_last, c;
    integer    n_mismatch, checks, n_wr, t, seed;
    sprs_slave dut (.clk_sys(clk_sys), .rst_n(rst_n), .host_or_rom_strap(strap),
        .spi_ss_n(ss_n), .spi_sck(sck), .spi_mosi(mosi), .spi_miso(miso),
        .spi_miso_oe_n(oe_n), .reg_page(page), .reg_addr(addr), .reg_wdata(wd),
        .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .reg_rvalid(rv),
        .host_port_sel(hps), .cmd_error(err));
    sprs_regs_model u_regs (.clk_sys(clk_sys), .reg_rd(rd), .reg_page(page),
        .reg_addr(addr), .reg_rdata(rdat), .reg_rvalid(rv));
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (wr === 1'b1) begin
            n_wr <= n_wr + 1;
            wa_prev <= wa_last;
            wa_last <= addr;
        end
        if (rd === 1'b1) ra_last <= addr;
    end
    task chk(input string nm, input [7:0] exp, input [7:0] got);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("Error %s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d n_mismatch %0d", checks, n_mismatch);
            if (n_mismatch == 0 && checks > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    function [7:0] exp_window(input [7:0] p, input [7:0] a);
        exp_window = p ^ a ^ 8'h5a;
    endfunction
    function [7:0] exp_status(input done, input ack);
        exp_status = {done, 1'b0, ack, 5'h00};
    endfunction
    task do_reset(input s);
        begin
            rst_n <= 1'b0;
            strap <= s;
            repeat (5) @(posedge clk_sys);
            rst_n <= 1'b1;
            repeat (8) @(posedge clk_sys);
        end
    endtask
    // one byte, msb first, 48 ns link period
    task xfer(input [7:0] tx, output [7:0] rx);
        integer i;
        for (i = 7; i >= 0; i = i - 1) begin
            sck <= 1'b0;
            mosi <= tx[i];
            repeat (6) @(posedge clk_sys);
            sck <= 1'b1;
            rx[i] = oe_n ? ~miso : miso;
            repeat (6) @(posedge clk_sys);
        end
    endtask
    task txn(input integer n);
        integer k;
        begin
            ss_n <= 1'b0;
            repeat (6) @(posedge clk_sys);
            for (k = 0; k < n; k = k + 1) xfer(tx_b[k], rx_b[k]);
            repeat (6) @(posedge clk_sys);
            ss_n <= 1'b1;
            repeat (60) @(posedge clk_sys);
            chk("oe_n", 8'h01, {7'h00, oe_n});
        end
    endtask
    task send(input [7:0] b0, input [7:0] b1, input [7:0] b2, input [7:0] b3,
              input integer n);
        begin
            tx_b[0] = b0;
            tx_b[1] = b1;
            tx_b[2] = b2;
            tx_b[3] = b3;
            txn(n);
        end
    endtask
    initial begin
        {rst_n, strap, ss_n, sck, mosi, n_wr} = 0;
        {ss_n, sck} = 2'h3;
        n_mismatch = 0;
        checks = 0;
        seed = $urandom(39394);
        do_reset(1'b1);
        chk("page_rst", 8'h00, page);
        for (t = 0; t < 4; t = t + 1) begin
            {d0, d1, pg, ad} = $urandom;
            ad = ad % 8'he8;
            send(8'h61, 8'hff, pg, 8'h00, 3);
            chk("page", pg, page);
            chk("cmd_ok", 8'h00, {7'h00, err});
            send(8'h60, ad, 8'h00, 8'h00, 3);
            chk("fetch_addr", ad, ra_last);
            send(8'h60, 8'hfe, 8'h00, 8'h00, 3);
            chk("status", exp_status(1'b1, 1'b1), rx_b[2]);
            send(8'h60, 8'hf0, 8'h00, 8'h00, 3);
            chk("window", exp_window(pg, ad), rx_b[2]);
            send(8'h60, 8'hfe, 8'h00, 8'h00, 3);
            chk("status_clr", exp_status(1'b1, 1'b0), rx_b[2]);
            send(8'h61, ad, d0, d1, 4);
            chk("wr_first", ad, wa_prev);
            chk("wr_next", ad + 8'h01, wa_last);
            chk("wdata", d1, wd);
            c = {t[2:0], 5'h10};
            send(c, ad, 8'h00, 8'h00, 2);
            chk("fast_addr", ad + {5'h00, t[2:0]}, ra_last);
        end
        for (t = 0; t < 4; t = t + 1) begin
            c = (t == 0) ? 8'h63 : (t == 1) ? 8'h41 : (t == 2) ? 8'h11 : 8'h65;
            d0 = n_wr[7:0];
            send(c, 8'h10, 8'h55, 8'h55, 3);
            chk("cmd_err", 8'h01, {7'h00, err});
            chk("no_write", d0, n_wr[7:0]);
        end
        xfer(8'h61, d0);
        xfer(8'hff, d0);
        xfer(8'h3c, d0);
        repeat (20) @(posedge clk_sys);
        chk("page_idle", pg, page);
        do_reset(1'b0);
        send(8'h61, 8'hff, 8'h3c, 8'h00, 3);
        chk("strap_sel", 8'h00, {7'h00, hps});
        chk("page_rom", 8'h00, page);
        finish_test;
    end
    initial begin
        repeat (50000) @(posedge clk_sys);
        n_mismatch = n_mismatch + 1;
        finish_test;
    end
endmodule
